// *** rtl/spc_port_top.sv ***
// Serial control port with its configuration registers and a small buffered user bank.
// Assumes serial pins synchronous to clk_i and an outside tristate built from the enables.
`timescale 1ns/1ns
module spc_port_top #(
    parameter int                        USER_COUNT   = 4,
    parameter logic [7:0]                VARIANT_ID   = 8'h5A, // Arbitrary value.
    parameter logic [USER_COUNT*8-1:0]   USER_DEFAULT = '0
) (
    // Clock, reset, enable
    input  wire logic                    clk_i,
    input  wire logic                    arst_n_i,
    input  wire logic                    ce_i,
    // Serial port pins
    input  wire logic                    sclk_i,
    input  wire logic                    cs_n_i,
    input  wire logic                    sdio_i,
    output logic                         sdio_o,
    output logic                         sdio_oe_o,
    output logic                         serial_output_pin_o,
    output logic                         serial_output_pin_oe_o,
    // Straps and stored values
    input  wire logic                    i2c_mode_i,
    input  wire logic                    nv_select_i,
    input  wire logic [USER_COUNT*8-1:0] nv_data_i,
    // Update and active values
    input  wire logic                    update_i,
    output logic [USER_COUNT*8-1:0]      user_active_o,
    output logic                         data_direction_select_o,
    output logic                         lsb_first_o
);
    import spc_pkg::*;

    // ****************************************************************
    // Elaboration check
    // ****************************************************************
    if (USER_COUNT < 1 || USER_COUNT > 64) begin : g_chk
        $error("spc_port_top supports 1 to 64 user registers.");
    end

    // ****************************************************************
    // Declarations
    // ****************************************************************
    spc_state_e  state_q, state_d;
    logic [3:0]  bit_cnt_q, bit_cnt_d;
    logic [1:0]  left_q, left_d;
    logic        stream_q, stream_d;
    logic        rw_q, rw_d;
    logic [12:0] addr_q, addr_d;
    logic        dout_q, dout_d;
    logic        rise, fall;
    logic        lsb_eff;
    logic        rd_phase;
    logic        wr_stb;
    logic [12:0] wr_addr;
    logic [7:0]  wr_data;
    logic [12:0] nxt_addr;

    logic        dir_q, dir_d;
    logic        ord_q, ord_d;
    logic        rb_sel_q, rb_sel_d;
    logic        boot_q, boot_d;
    logic        reload;
    logic [7:0]  buf_q [USER_COUNT];
    logic [7:0]  buf_d [USER_COUNT];
    logic [7:0]  act_q [USER_COUNT];
    logic [7:0]  act_d [USER_COUNT];

    spc_shift_if #(.W(INSTR_W)) ins_if ();
    spc_shift_if #(.W(DATA_W))  rxd_if ();
    spc_shift_if #(.W(DATA_W))  txd_if ();

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic user_hit(input logic [12:0] a, input int i);
        user_hit = (a == 13'(ADDR_USER_BASE + 13'(i)));
    endfunction : user_hit

    function automatic logic [7:0] read_mux(input logic [12:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == ADDR_PORT_CFG) begin
            if (i2c_mode_i) begin
                v = 8'h00;
            end else begin
                v = {dir_q, ord_q, 2'b00, 2'b00, ord_q, dir_q};
            end
        end else if (a == ADDR_VARIANT) begin
            v = VARIANT_ID;
        end else if (a == ADDR_RB_SEL) begin
            v = {7'h00, rb_sel_q};
        end else begin
            for (int i = 0; i < USER_COUNT; i++) begin
                if (user_hit(a, i)) begin
                    v = rb_sel_q ? act_q[i] : buf_q[i];
                end
            end
        end
        read_mux = v;
    endfunction : read_mux

    // ****************************************************************
    // Serial clock edges and shift registers
    // ****************************************************************
    spc_edge_detect u_edge (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .ce_i     (ce_i),
        .sclk_i   (sclk_i),
        .cs_n_i   (cs_n_i),
        .rise_o   (rise),
        .fall_o   (fall)
    );

    spc_order_shift #(.W(INSTR_W)) u_ins (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .ce_i     (ce_i),
        .sh       (ins_if.shreg)
    );

    spc_order_shift #(.W(DATA_W)) u_rxd (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .ce_i     (ce_i),
        .sh       (rxd_if.shreg)
    );

    spc_order_shift #(.W(DATA_W)) u_txd (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .ce_i     (ce_i),
        .sh       (txd_if.shreg)
    );

    // In I2C mode the order bit is kept but has no effect, so a later switch back restores it.
    assign lsb_eff  = ord_q & ~i2c_mode_i;
    assign nxt_addr = spc_step_addr(addr_q, lsb_eff);

    // ****************************************************************
    // Frame engine
    // ****************************************************************
    always_comb begin
        state_d   = state_q;
        bit_cnt_d = bit_cnt_q;
        left_d    = left_q;
        stream_d  = stream_q;
        rw_d      = rw_q;
        addr_d    = addr_q;
        dout_d    = dout_q;
        wr_stb    = 1'b0;
        wr_addr   = addr_q;
        wr_data   = rxd_if.word_next;

        ins_if.load      = 1'b0;
        ins_if.load_val  = '0;
        ins_if.shift     = 1'b0;
        ins_if.bit_in    = sdio_i;
        ins_if.lsb_first = lsb_eff;
        rxd_if.load      = 1'b0;
        rxd_if.load_val  = '0;
        rxd_if.shift     = 1'b0;
        rxd_if.bit_in    = sdio_i;
        rxd_if.lsb_first = lsb_eff;
        txd_if.load      = 1'b0;
        txd_if.load_val  = '0;
        txd_if.shift     = 1'b0;
        txd_if.bit_in    = 1'b0;
        txd_if.lsb_first = lsb_eff;

        if (cs_n_i) begin
            state_d = ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    state_d   = ST_INSTR;
                    bit_cnt_d = 4'h0;
                end
                ST_INSTR: begin
                    if (rise) begin
                        ins_if.shift = 1'b1;
                        bit_cnt_d    = 4'(bit_cnt_q + 4'h1);
                        if (bit_cnt_q == INSTR_LAST_BIT) begin
                            rw_d      = ins_if.word_next[INS_RW_BIT];
                            addr_d    = ins_if.word_next[ADDR_W-1:0];
                            left_d    = ins_if.word_next[INS_CNT_HI:INS_CNT_LO];
                            stream_d  = (ins_if.word_next[INS_CNT_HI:INS_CNT_LO] == CNT_STREAM);
                            bit_cnt_d = 4'h0;
                            state_d   = ST_DATA;
                            if (ins_if.word_next[INS_RW_BIT]) begin
                                txd_if.load     = 1'b1;
                                txd_if.load_val = read_mux(ins_if.word_next[ADDR_W-1:0]);
                            end
                        end
                    end
                end
                ST_DATA: begin
                    if (rise) begin
                        rxd_if.shift = ~rw_q;
                        bit_cnt_d    = 4'(bit_cnt_q + 4'h1);
                        if (bit_cnt_q == BYTE_LAST_BIT) begin
                            bit_cnt_d = 4'h0;
                            wr_stb    = ~rw_q;
                            addr_d    = nxt_addr;
                            if (!stream_q && left_q == 2'h0) begin
                                state_d = ST_HOLD;
                            end else begin
                                left_d = stream_q ? left_q : 2'(left_q - 2'h1);
                                if (rw_q) begin
                                    txd_if.load     = 1'b1;
                                    txd_if.load_val = read_mux(nxt_addr);
                                end
                            end
                        end
                    end else if (fall && rw_q) begin
                        dout_d       = txd_if.bit_out;
                        txd_if.shift = 1'b1;
                    end
                end
                ST_HOLD: begin
                    state_d = ST_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q   <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            left_q    <= 2'h0;
            stream_q  <= 1'b0;
            rw_q      <= 1'b0;
            addr_q    <= 13'h000;
            dout_q    <= 1'b0;
        end else if (ce_i) begin
            state_q   <= state_d;
            bit_cnt_q <= bit_cnt_d;
            left_q    <= left_d;
            stream_q  <= stream_d;
            rw_q      <= rw_d;
            addr_q    <= addr_d;
            dout_q    <= dout_d;
        end
    end

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    assign rd_phase               = (state_q == ST_DATA) & rw_q & ~cs_n_i;
    assign sdio_o                 = dout_q;
    assign sdio_oe_o              = rd_phase & ~dir_q;
    assign serial_output_pin_o    = dout_q;
    assign serial_output_pin_oe_o = rd_phase & dir_q;

    // ****************************************************************
    // Register bank
    // ****************************************************************
    // The low nibble of the port word is never stored; it is rebuilt on read from the high bits.
    assign reload = boot_q | (wr_stb & (wr_addr == ADDR_PORT_CFG) & wr_data[CFG_SRST_BIT]);

    always_comb begin
        dir_d    = dir_q;
        ord_d    = ord_q;
        rb_sel_d = rb_sel_q;
        boot_d   = 1'b0;
        buf_d    = buf_q;
        act_d    = act_q;
        if (reload) begin
            dir_d    = CFG_DIR_RST;
            ord_d    = CFG_ORDER_RST;
            rb_sel_d = RB_SEL_RST;
            for (int i = 0; i < USER_COUNT; i++) begin
                buf_d[i] = nv_select_i ? nv_data_i[i*8 +: 8] : USER_DEFAULT[i*8 +: 8];
                act_d[i] = buf_d[i];
            end
        end else begin
            if (update_i) begin
                act_d = buf_q;
            end
            if (wr_stb) begin
                if (wr_addr == ADDR_PORT_CFG && !i2c_mode_i) begin
                    dir_d = wr_data[CFG_DIR_BIT];
                    ord_d = wr_data[CFG_ORDER_BIT];
                end else if (wr_addr == ADDR_RB_SEL) begin
                    rb_sel_d = wr_data[RB_SEL_BIT];
                end
                for (int i = 0; i < USER_COUNT; i++) begin
                    if (user_hit(wr_addr, i)) begin
                        buf_d[i] = wr_data;
                    end
                end
            end
        end
    end

    // The storage pin is only read by a clocked reload, one enabled cycle after reset release or on a soft reset write.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dir_q    <= CFG_DIR_RST;
            ord_q    <= CFG_ORDER_RST;
            rb_sel_q <= RB_SEL_RST;
            boot_q   <= 1'b1;
            for (int i = 0; i < USER_COUNT; i++) begin
                buf_q[i] <= 8'h00;
                act_q[i] <= 8'h00;
            end
        end else if (ce_i) begin
            dir_q    <= dir_d;
            ord_q    <= ord_d;
            rb_sel_q <= rb_sel_d;
            boot_q   <= boot_d;
            buf_q    <= buf_d;
            act_q    <= act_d;
        end
    end

    // ****************************************************************
    // Status outputs
    // ****************************************************************
    always_comb begin
        for (int i = 0; i < USER_COUNT; i++) begin
            user_active_o[i*8 +: 8] = act_q[i];
        end
    end

    assign data_direction_select_o = dir_q;
    assign lsb_first_o             = lsb_eff;

endmodule : spc_port_top

// *** pkg/spc_pkg.sv ***
// Constants, state codes and the address step function of the serial port configuration bank.
// Assumes one 10 MHz clock and serial pins that are already synchronous to it.
//
// How it works
// - With the direction bit (bit 7) at 0, reads come out on the data pin and the serial output pin stays undriven.
// - With the direction bit at 1, reads come out on the serial output pin and writes still enter on the data pin.
// - With the order bit (bit 6) at 0, bits move most significant first and the address steps down per byte.
// - With the order bit at 1, bits move least significant first and the address steps up per byte.
// - In I2C mode the order bit is ignored and the port behaves as if it were 0 for bit order.
// - Writing 1 to bit 5 reloads all registers and the bit never reads back; a high storage pin loads stored values.
// - With the storage pin low, that reload uses the built-in defaults instead.
// - Address 0x003 reads a fixed 8-bit variant code, and writes to it do nothing.
// - Bit 0 of address 0x004 at 0 makes reads return the buffer registers.
// - That bit at 1 makes reads return the active registers that steer the device.
// - In I2C mode bits 7 and 6 of the port word read as 0 and ignore writes; the held bit 7 still steers the read pins.
package spc_pkg;

    // ****************************************************************
    // Widths and addresses
    // ****************************************************************
    localparam int          ADDR_W         = 13;
    localparam int          DATA_W         = 8;
    localparam int          INSTR_W        = 16;
    localparam logic [12:0] ADDR_PORT_CFG  = 13'h000;
    localparam logic [12:0] ADDR_VARIANT   = 13'h003;
    localparam logic [12:0] ADDR_RB_SEL    = 13'h004;
    localparam logic [12:0] ADDR_USER_BASE = 13'h010;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int          CFG_DIR_BIT    = 7;
    localparam int          CFG_ORDER_BIT  = 6;
    localparam int          CFG_SRST_BIT   = 5;
    localparam int          RB_SEL_BIT     = 0;
    localparam logic        CFG_DIR_RST    = 1'b0;
    localparam logic        CFG_ORDER_RST  = 1'b0;
    localparam logic        RB_SEL_RST     = 1'b0;
    localparam int          INS_RW_BIT     = 15;
    localparam int          INS_CNT_HI     = 14;
    localparam int          INS_CNT_LO     = 13;
    localparam logic [1:0]  CNT_STREAM     = 2'h3;
    localparam logic [3:0]  INSTR_LAST_BIT = 4'hF;
    localparam logic [3:0]  BYTE_LAST_BIT  = 4'h7;

    // ****************************************************************
    // Frame engine states
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_INSTR = 4'b0010,
        ST_DATA  = 4'b0100,
        ST_HOLD  = 4'b1000
    } spc_state_e;

    // Next address of a multi-byte transfer.
    function automatic logic [12:0] spc_step_addr(input logic [12:0] a, input logic up);
        spc_step_addr = up ? 13'(a + 13'h001) : 13'(a - 13'h001);
    endfunction : spc_step_addr

endpackage : spc_pkg

// *** pkg/spc_shift_if.sv ***
// Control and data lines between the frame engine and one shift register.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ns
interface spc_shift_if #(parameter int W = 8);
    logic         load;
    logic [W-1:0] load_val;
    logic         shift;
    logic         bit_in;
    logic         lsb_first;
    logic [W-1:0] word;
    logic [W-1:0] word_next;
    logic         bit_out;

    modport ctrl  (output load, load_val, shift, bit_in, lsb_first, input word, word_next, bit_out);
    modport shreg (input load, load_val, shift, bit_in, lsb_first, output word, word_next, bit_out);
endinterface : spc_shift_if

// *** rtl/spc_order_shift.sv ***
// Shift register that moves either end first, as the port's bit order asks.
// Assumes load and shift are never high together; load wins if they are.
`timescale 1ns/1ns
module spc_order_shift #(
    parameter int W = 8
) (
    // Clock, reset, enable
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic ce_i,
    // Control side
    spc_shift_if.shreg sh
);
    import spc_pkg::*;

    logic [W-1:0] word_q;
    logic [W-1:0] word_d;

    if (W < 2) begin : g_chk
        $error("spc_order_shift needs at least two bits.");
    end

    // The shifted value is offered early so the engine can decode on the closing edge.
    always_comb begin
        sh.word_next = sh.lsb_first ? {sh.bit_in, word_q[W-1:1]} : {word_q[W-2:0], sh.bit_in};
        if (sh.load) begin
            word_d = sh.load_val;
        end else if (sh.shift) begin
            word_d = sh.word_next;
        end else begin
            word_d = word_q;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            word_q <= '0;
        end else if (ce_i) begin
            word_q <= word_d;
        end
    end

    assign sh.word    = word_q;
    assign sh.bit_out = sh.lsb_first ? word_q[0] : word_q[W-1];

endmodule : spc_order_shift

// *** rtl/spc_edge_detect.sv ***
// Finds rising and falling edges of the serial clock while the port is selected.
// Assumes the pins are synchronous to clk_i and the serial clock is at most a quarter of it.
`timescale 1ns/1ns
module spc_edge_detect (
    // Clock, reset, enable
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic ce_i,
    // Pins
    input  wire logic sclk_i,
    input  wire logic cs_n_i,
    // Edges
    output logic      rise_o,
    output logic      fall_o
);
    import spc_pkg::*;

    logic sclk_q;
    logic sclk_d;

    always_comb begin
        sclk_d = sclk_i;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_q <= 1'b0;
        end else if (ce_i) begin
            sclk_q <= sclk_d;
        end
    end

    // Edges are masked by ce so that a frozen block never acts on a stale edge twice.
    assign rise_o = ce_i & ~cs_n_i & sclk_i & ~sclk_q;
    assign fall_o = ce_i & ~cs_n_i & ~sclk_i & sclk_q;

endmodule : spc_edge_detect

// *** verification/spc_port_monitor.sv ***
// Port checker for the serial configuration bank.
// Assumes one clock domain; bound onto spc_port_top.
`timescale 1ns/1ns
module spc_port_monitor #(parameter int UC = 4) (
    // Clock and reset
    input logic            clk_i,
    input logic            arst_n_i,
    // Serial pins and straps
    input logic            sclk_i,
    input logic            cs_n_i,
    input logic            i2c_mode_i,
    input logic            update_i,
    input logic            sdio_o,
    input logic            sdio_oe_o,
    input logic            serial_output_pin_oe_o,
    // Configuration outputs
    input logic [UC*8-1:0] user_active_o,
    input logic            data_direction_select_o,
    input logic            lsb_first_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // Two idle cycles: no frame can still be landing.
    sequence s_port_idle;
        cs_n_i ##1 cs_n_i;
    endsequence
    a_oe_exclusive: assert property (!(sdio_oe_o && serial_output_pin_oe_o))
        else $error("both read outputs enabled");
    a_sdo_bidir: assert property (!data_direction_select_o |-> !serial_output_pin_oe_o)
        else $error("serial output driven in bidirectional mode");
    a_sdio_unidir: assert property (data_direction_select_o |-> !sdio_oe_o)
        else $error("data pin driven in unidirectional mode");
    a_oe_needs_select: assert property (cs_n_i |-> !sdio_oe_o && !serial_output_pin_oe_o)
        else $error("read output enabled while deselected");
    a_i2c_order: assert property (i2c_mode_i |-> !lsb_first_o)
        else $error("order bit honoured in I2C mode");
    a_i2c_dir_kept: assert property (i2c_mode_i && $past(i2c_mode_i) && !$past(data_direction_select_o)
        |-> !data_direction_select_o) else $error("direction bit written in I2C mode");
    a_cfg_idle: assert property (s_port_idle |-> $stable(data_direction_select_o))
        else $error("direction changed outside a frame");
    a_active_hold: assert property (s_port_idle ##0 (!$past(update_i) && $past(arst_n_i, 2))
        |-> $stable(user_active_o)) else $error("active bank changed without update");
    a_dout_on_fall: assert property (sdio_oe_o && $past(sdio_oe_o) && $changed(sdio_o)
        |-> !$past(sclk_i)) else $error("read bit changed off a falling serial clock");
endmodule : spc_port_monitor
bind spc_port_top spc_port_monitor #(.UC(USER_COUNT)) spc_port_monitor_i (.clk_i, .arst_n_i,
    .sclk_i, .cs_n_i, .i2c_mode_i, .update_i, .sdio_o, .sdio_oe_o, .serial_output_pin_oe_o,
    .user_active_o, .data_direction_select_o, .lsb_first_o);

// *** verification/spc_host_model.sv ***
// Behavioural serial host that frames register accesses.
// Assumes the bench fills q before writes; read bytes come back in q.
`timescale 1ns/1ns
module spc_host_model (
    // Clock
    input  logic clk_i,
    // Pins
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdio_o,
    input  logic dev_sdio_i,
    input  logic dev_sdio_oe_i,
    input  logic dev_so_i,
    input  logic dev_so_oe_i
);
    logic [7:0] q[$];
    logic       hv = 1'b0;
    logic       so_last = 1'b0;
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
    end
    // A released line shows its inverse, never a stale copy.
    assign sdio_o = dev_sdio_oe_i ? dev_sdio_i : hv;
    always @(posedge clk_i) if (dev_so_oe_i) so_last <= dev_so_i;
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_i);
    endtask : wait_n
    task automatic bit_io(input logic b, rd, uni, output logic r);
        sclk_o = 1'b0;
        hv = rd ? ~hv : b;
        wait_n(3);
        r = uni ? (dev_so_oe_i ? dev_so_i : ~so_last) : sdio_o;
        sclk_o = 1'b1;
        wait_n(3);
    endtask : bit_io
    task automatic xfer(input logic rd, input logic [12:0] a, input int n, input logic lsb, uni);
        logic [15:0] ins;
        logic [7:0]  b;
        logic        r;
        ins = {rd, 2'(n - 1), a};
        cs_n_o = 1'b0;
        wait_n(2);
        for (int i = 0; i < 16; i++) bit_io(ins[lsb ? i : 15 - i], 1'b0, 1'b0, r);
        for (int j = 0; j < n; j++) begin
            b = rd ? 8'h00 : q[j];
            for (int i = 0; i < 8; i++) begin
                bit_io(b[lsb ? i : 7 - i], rd, uni, r);
                if (rd) b[lsb ? i : 7 - i] = r;
            end
            if (rd) q[j] = b;
        end
        sclk_o = 1'b0;
        hv = ~hv;
        wait_n(2);
        cs_n_o = 1'b1;
        wait_n(3);
    endtask : xfer
endmodule : spc_host_model

// *** verification/spc_port_top_test.sv ***
// Self-checking bench for the serial configuration bank.
// Assumes the host model and the bound checker beside it.
`timescale 1ns/1ns
module spc_port_top_test;
    import spc_pkg::*;
    localparam logic [7:0] VID = 8'h3C; // Arbitrary value.
    localparam logic [12:0] ADDR_LIST [4] = '{13'h000, 13'h003, 13'h004, 13'h008};
    logic clk_i = 1'b0, arst_n_i = 1'b0, i2c_mode_i = 1'b0, nv_select_i = 1'b1, update_i = 1'b0;
    logic [31:0] nv_data_i = '0, act_o;
    logic sclk, cs_n, sdio_in, sdio_o, sdio_oe_o, so_o, so_oe_o, dir_o, lsb_o;
    logic [7:0] bufm[4], actm[4];
    logic dir, ord, rbs;
    int num_errors = 0, cmp_count = 0, cyc = 0;
    always #50 clk_i = ~clk_i;
    spc_port_top #(.VARIANT_ID(VID)) spc_port_top_i (.clk_i, .arst_n_i, .ce_i(1'b1), .sclk_i(sclk),
        .cs_n_i(cs_n), .sdio_i(sdio_in), .sdio_o, .sdio_oe_o, .serial_output_pin_o(so_o),
        .serial_output_pin_oe_o(so_oe_o), .i2c_mode_i, .nv_select_i, .nv_data_i, .update_i,
        .user_active_o(act_o), .data_direction_select_o(dir_o), .lsb_first_o(lsb_o));
    spc_host_model spc_host_model_i (.clk_i, .sclk_o(sclk), .cs_n_o(cs_n), .sdio_o(sdio_in),
        .dev_sdio_i(sdio_o), .dev_sdio_oe_i(sdio_oe_o), .dev_so_i(so_o), .dev_so_oe_i(so_oe_o));
    // ********
    // Reference model and checks
    // ********
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [7:0] exp_rd(input logic [12:0] a);
        if (a == ADDR_PORT_CFG) return {dir, ord, 4'h0, ord, dir};
        if (a == ADDR_VARIANT) return VID;
        if (a == ADDR_RB_SEL) return {7'h00, rbs};
        if (a[12:2] == ADDR_USER_BASE[12:2]) return rbs ? actm[a[1:0]] : bufm[a[1:0]];
        return 8'h00;
    endfunction : exp_rd
    task automatic reload();
        for (int i = 0; i < 4; i++) begin
            bufm[i] = nv_select_i ? nv_data_i[8*i+:8] : 8'h00;
            actm[i] = bufm[i];
        end
        {dir, ord, rbs} = 3'h0;
    endtask : reload
    task automatic mwr(input logic [12:0] a, input logic [7:0] v);
        if (a == ADDR_PORT_CFG && v[CFG_SRST_BIT]) reload();
        else if (a == ADDR_PORT_CFG && !i2c_mode_i) {dir, ord} = v[7:6];
        else if (a == ADDR_RB_SEL) rbs = v[RB_SEL_BIT];
        else if (a[12:2] == ADDR_USER_BASE[12:2]) bufm[a[1:0]] = v;
    endtask : mwr
    task automatic acc(input logic rd, input logic [12:0] a, input int n);
        logic up;
        up = ord & ~i2c_mode_i;
        spc_host_model_i.xfer(rd, a, n, up, dir);
        for (int j = 0; j < n; j++) begin
            if (rd) chk({24'h0, spc_host_model_i.q[j]}, {24'h0, exp_rd(a)});
            else mwr(a, spc_host_model_i.q[j]);
            a = up ? a + 13'h001 : a - 13'h001;
        end
    endtask : acc
    task automatic wr(input logic [12:0] a, input logic [7:0] v);
        spc_host_model_i.q = {v};
        acc(1'b0, a, 1);
    endtask : wr
    task automatic chk_cfg();
        chk(act_o, {actm[3], actm[2], actm[1], actm[0]});
        chk({30'h0, dir_o, lsb_o}, {30'h0, dir, ord & ~i2c_mode_i});
    endtask : chk_cfg
    always @(posedge clk_i) if (++cyc == 20000) begin
        num_errors++;
        end_sim();
    end
    // ********
    // Tests
    // ********
    initial begin
        void'($urandom(32'h132f));
        nv_data_i = $urandom();
        repeat (20) @(negedge clk_i);
        arst_n_i = 1'b1;
        reload();
        repeat (3) @(negedge clk_i);
        chk_cfg();
        foreach (ADDR_LIST[i]) acc(1'b1, ADDR_LIST[i], 1);
        acc(1'b1, 13'h013, 4);
        $display("test reset done");
        spc_host_model_i.q = {8'($urandom()), 8'($urandom())};
        acc(1'b0, 13'h011, 2);
        acc(1'b1, 13'h011, 2);
        chk_cfg();
        update_i = 1'b1;
        @(negedge clk_i);
        update_i = 1'b0;
        actm = bufm;
        @(negedge clk_i);
        chk_cfg();
        wr(ADDR_RB_SEL, 8'h01);
        wr(13'h012, 8'($urandom()));
        acc(1'b1, 13'h013, 4);
        wr(ADDR_RB_SEL, 8'h00);
        $display("test banks done");
        wr(ADDR_VARIANT, 8'($urandom()));
        wr(13'h008, 8'($urandom()));
        acc(1'b1, ADDR_VARIANT, 1);
        acc(1'b1, 13'h008, 1);
        wr(ADDR_PORT_CFG, 8'h81);
        chk_cfg();
        acc(1'b1, 13'h011, 2);
        acc(1'b1, ADDR_PORT_CFG, 1);
        $display("test direction done");
        wr(ADDR_PORT_CFG, 8'h42);
        chk_cfg();
        spc_host_model_i.q = {8'($urandom()), 8'($urandom()), 8'($urandom())};
        acc(1'b0, 13'h010, 3);
        acc(1'b1, 13'h010, 4);
        $display("test order done");
        i2c_mode_i = 1'b1;
        @(negedge clk_i);
        chk_cfg();
        wr(ADDR_PORT_CFG, 8'hC3);
        chk_cfg();
        wr(13'h013, 8'($urandom()));
        acc(1'b1, 13'h013, 2);
        i2c_mode_i = 1'b0;
        @(negedge clk_i);
        chk_cfg();
        $display("test i2c done");
        nv_select_i = 1'b0;
        wr(ADDR_PORT_CFG, 8'h24);
        chk_cfg();
        nv_select_i = 1'b1;
        nv_data_i = $urandom();
        wr(ADDR_PORT_CFG, 8'h24);
        chk_cfg();
        acc(1'b1, 13'h013, 4);
        acc(1'b1, ADDR_PORT_CFG, 1);
        $display("test soft reset done");
        end_sim();
    end
endmodule : spc_port_top_test
